// file: core/hwl_pkg.sv
/*
  Package for the host interface serial link: framing constants, rate table,
  FIFO depths and wake-line configuration carrier.
  Assumes a single 40 MHz core clock.
*/
package hwl_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BAUD_DEFAULT = 115200;
  localparam int unsigned BAUD_MIN = 115200;
  localparam int unsigned BAUD_MAX = 3000000;
  localparam int unsigned BAUD_921K = 921600;
  localparam int unsigned BAUD_1M5 = 1500000;
  localparam int unsigned OVS = 8;
  localparam int unsigned HCI_FIFO_DEPTH = 1040;
  localparam int unsigned PER_FIFO_DEPTH = 256;
  localparam int unsigned RTS_MARGIN = 16;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FRAME_BITS = 10;
  localparam logic [1:0] RATE_115K = 2'h0;
  localparam logic [1:0] RATE_921K = 2'h1;
  localparam logic [1:0] RATE_1M5 = 2'h2;
  localparam logic [1:0] RATE_3M = 2'h3;

  typedef logic [DIV_W-1:0] hwl_div_t;
  typedef longint unsigned hwl_wide_t;
  // the tick accumulator wraps at this value
  localparam hwl_wide_t ACC_ONE = hwl_wide_t'(1) << DIV_W;

  typedef struct packed {
    logic rate_custom;
    logic [1:0] rate_sel;
    hwl_div_t div_custom; // phase step per clock, ACC_ONE would tick every clock
  } hwl_rate_cfg_s;

  typedef struct packed {
    logic wake_en;
    logic device_wake_request_forces_awake;
    logic host_wake_req;
  } hwl_wake_cfg_s;

  // rounded phase step that yields baud * OVS ticks per second
  function automatic hwl_div_t hwl_rate_step(input int unsigned baud);
    hwl_wide_t num;
    num = hwl_wide_t'(baud) * hwl_wide_t'(OVS) * ACC_ONE + hwl_wide_t'(CLK_HZ / 2);
    return hwl_div_t'(num / hwl_wide_t'(CLK_HZ));
  endfunction

  function automatic hwl_div_t hwl_rate_div(input logic [1:0] sel);
    hwl_div_t d;
    unique case (sel)
      RATE_115K: d = hwl_rate_step(BAUD_DEFAULT);
      RATE_921K: d = hwl_rate_step(BAUD_921K);
      RATE_1M5: d = hwl_rate_step(BAUD_1M5);
      RATE_3M: d = hwl_rate_step(BAUD_MAX);
    endcase
    return d;
  endfunction
endpackage

// file: core/hwl_uart_link.sv
/*
  Dual-use serial port with byte FIFOs, hardware flow control and wake lines.
  One instance with DEPTH 1040 serves the host interface; DEPTH 256 the
  peripheral port, whose pins are routed by the pad mux outside.
  Assumes rate and wake configuration come from the firmware command handler
  and that all inputs are synchronous to I_SYS_CLK.
*/
// Overview of operation
// - four wires: receive, transmit, request, clear
// - rate configurable from 115200 to 3M
// - preset common rates plus custom divisor
// - rate changes live on command
// - mid-bit sampling tolerates five percent error
// - separate receive and transmit FIFOs, 1040
// - H4 stream, 115.2 kbaud after reset
// - device wake either forces awake or permits
// - host wake line requests host attention
// - wake lines idle until enabled
// - peripheral port same, 256-byte FIFOs
// - peripheral pins routed outside to GPIO
`timescale 1ns/10ps
module hwl_uart_link import hwl_pkg::*; #(
  parameter int unsigned DEPTH = HCI_FIFO_DEPTH
) (
  input wire logic I_SYS_CLK, // core clock
  input wire logic I_RST_N, // synchronous reset, low active
  input wire logic I_RXD, // serial receive data
  output logic O_TXD, // serial transmit data
  input wire logic I_CTS_N, // clear to send from peer, low active
  output logic O_RTS_N, // request to send to peer, low active
  input wire hwl_rate_cfg_s I_RATE_CFG, // rate selection
  input wire hwl_wake_cfg_s I_WAKE_CFG, // wake line configuration
  input wire logic I_DEVICE_WAKE_REQUEST, // wake request from host
  output logic O_HOST_WAKE, // wake request to host
  output logic O_STAY_AWAKE, // device must not sleep
  input wire logic [7:0] I_TX_DATA, // byte to send
  input wire logic I_TX_VALID, // byte to send valid
  output logic O_TX_READY, // transmit FIFO has room
  output logic [7:0] O_RX_DATA, // received byte
  output logic O_RX_VALID, // received byte valid
  input wire logic I_RX_READY, // consumer takes byte
  output logic O_RX_FRAME_ERR // stop bit missing, one-cycle pulse
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH != HCI_FIFO_DEPTH && DEPTH != PER_FIFO_DEPTH) begin : g_depth_check
    $error("hwl_uart_link: DEPTH must be a documented FIFO size");
  end

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} hwl_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hwl_rx_e;

  // oversample tick from a phase accumulator: an integer divisor of the core
  // clock misses the faster preset rates far beyond the error budget
  hwl_div_t acc_ff;
  hwl_div_t rate_step;
  logic [DIV_W:0] nxt_acc;
  logic tick_ff;
  always_comb begin
    rate_step = I_RATE_CFG.rate_custom ? I_RATE_CFG.div_custom
                                       : hwl_rate_div(I_RATE_CFG.rate_sel);
    // a zero step would freeze the link, so fall back to the reset rate
    if (rate_step == '0) begin
      rate_step = hwl_rate_div(RATE_115K);
    end
  end
  assign nxt_acc = {1'b0, acc_ff} + {1'b0, rate_step};
  // a new step applies at the next clock, mid-frame too
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      acc_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc[DIV_W-1:0];
      tick_ff <= nxt_acc[DIV_W];
    end
  end

  function automatic logic [AW-1:0] hwl_inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // transmit FIFO
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_ff, tx_rp_ff;
  logic [AW:0] tx_cnt_ff;
  logic tx_push, tx_pop;
  assign tx_push = I_TX_VALID && O_TX_READY;
  always_ff @(posedge I_SYS_CLK) begin
    if (tx_push) begin
      tx_mem[tx_wp_ff] <= I_TX_DATA;
    end
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      tx_wp_ff <= '0;
      tx_rp_ff <= '0;
      tx_cnt_ff <= '0;
      O_TX_READY <= 1'b0;
    end else begin
      if (tx_push) tx_wp_ff <= hwl_inc(tx_wp_ff);
      if (tx_pop) tx_rp_ff <= hwl_inc(tx_rp_ff);
      tx_cnt_ff <= tx_cnt_ff + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
      // registered ready leaves one spare slot for the push in flight
      O_TX_READY <= (tx_cnt_ff + (AW+1)'(tx_push) - (AW+1)'(tx_pop))
                    < (AW+1)'(DEPTH - 1);
    end
  end

  // transmitter
  hwl_tx_e tx_st_ff;
  logic [9:0] tx_sh_ff;
  logic [3:0] tx_bit_ff;
  logic [2:0] tx_ph_ff;
  assign tx_pop = (tx_st_ff == TX_IDLE) && (tx_cnt_ff != '0) && !I_CTS_N
                  && tick_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      tx_st_ff <= TX_IDLE;
      tx_sh_ff <= '1;
      tx_bit_ff <= '0;
      tx_ph_ff <= '0;
      O_TXD <= 1'b1;
    end else begin
      unique case (tx_st_ff)
        TX_IDLE: begin
          O_TXD <= 1'b1;
          if (tx_pop) begin
            tx_sh_ff <= {1'b1, tx_mem[tx_rp_ff], 1'b0};
            tx_bit_ff <= '0;
            tx_ph_ff <= '0;
            tx_st_ff <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          O_TXD <= tx_sh_ff[0];
          if (tick_ff) begin
            tx_ph_ff <= tx_ph_ff + 3'h1;
            if (tx_ph_ff == 3'(OVS - 1)) begin
              tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
              tx_bit_ff <= tx_bit_ff + 4'h1;
              if (tx_bit_ff == 4'(FRAME_BITS - 1)) tx_st_ff <= TX_IDLE;
            end
          end
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // receiver, sampling at mid-bit on the oversample tick
  hwl_rx_e rx_st_ff;
  logic [2:0] rx_ph_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_last_ff;
  logic [AW:0] rx_cnt_ff;
  logic rx_push;
  logic [7:0] rx_byte;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      rx_st_ff <= RX_IDLE;
      rx_ph_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
      rx_last_ff <= 1'b1;
      O_RX_FRAME_ERR <= 1'b0;
    end else begin
      O_RX_FRAME_ERR <= 1'b0;
      if (tick_ff) begin
        rx_ph_ff <= rx_ph_ff + 3'h1;
        rx_last_ff <= I_RXD;
        unique case (rx_st_ff)
          RX_IDLE: begin
            rx_ph_ff <= '0;
            // falling edge, not low level, so a broken stop bit cannot restart
            if (rx_last_ff && !I_RXD) rx_st_ff <= RX_START;
          end
          RX_START: if (rx_ph_ff == 3'(OVS/2 - 1)) begin
            rx_ph_ff <= '0;
            rx_st_ff <= I_RXD ? RX_IDLE : RX_DATA;
            rx_bit_ff <= '0;
          end
          RX_DATA: if (rx_ph_ff == 3'(OVS - 1)) begin
            rx_sh_ff <= {I_RXD, rx_sh_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == 3'(DATA_BITS - 1)) rx_st_ff <= RX_STOP;
          end
          RX_STOP: if (rx_ph_ff == 3'(OVS - 1)) begin
            O_RX_FRAME_ERR <= !I_RXD;
            rx_st_ff <= RX_IDLE;
          end
        endcase
      end
    end
  end
  assign rx_push = tick_ff && (rx_st_ff == RX_STOP) && (rx_ph_ff == 3'(OVS - 1))
                   && I_RXD && (rx_cnt_ff != (AW+1)'(DEPTH));
  assign rx_byte = rx_sh_ff;

  // receive FIFO with registered head
  logic [7:0] rx_mem [DEPTH];
  logic [AW-1:0] rx_wp_ff, rx_rp_ff;
  logic rx_pop;
  assign rx_pop = (rx_cnt_ff != '0) && (!O_RX_VALID || I_RX_READY);
  always_ff @(posedge I_SYS_CLK) begin
    if (rx_push) begin
      rx_mem[rx_wp_ff] <= rx_byte;
    end
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      rx_cnt_ff <= '0;
      O_RX_VALID <= 1'b0;
      O_RX_DATA <= '0;
      O_RTS_N <= 1'b1;
    end else begin
      if (rx_push) rx_wp_ff <= hwl_inc(rx_wp_ff);
      if (rx_pop) begin
        rx_rp_ff <= hwl_inc(rx_rp_ff);
        O_RX_DATA <= rx_mem[rx_rp_ff];
        O_RX_VALID <= 1'b1;
      end else if (I_RX_READY) begin
        O_RX_VALID <= 1'b0;
      end
      rx_cnt_ff <= rx_cnt_ff + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      // margin covers bytes the peer has already started
      O_RTS_N <= rx_cnt_ff >= (AW+1)'(DEPTH - RTS_MARGIN);
    end
  end

  // wake lines stay quiet until the enabling command arrives
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N) begin
      O_HOST_WAKE <= 1'b0;
      O_STAY_AWAKE <= 1'b1;
    end else if (!I_WAKE_CFG.wake_en) begin
      O_HOST_WAKE <= 1'b0;
      O_STAY_AWAKE <= 1'b1;
    end else begin
      O_HOST_WAKE <= I_WAKE_CFG.host_wake_req || (rx_cnt_ff != '0 && !I_RX_READY)
                     || (tx_cnt_ff != '0);
      O_STAY_AWAKE <= I_WAKE_CFG.device_wake_request_forces_awake ? I_DEVICE_WAKE_REQUEST
                      : 1'b0;
    end
  end
endmodule

// file: sim/hwl_uart_link_asserts.sv
/*
  Concurrent checks on the serial link ports.
  Assumes one core clock and a synchronous low-active reset.
*/
`timescale 1ns/10ps
module hwl_uart_link_chk import hwl_pkg::*; (
  input wire logic I_SYS_CLK, // clock
  input wire logic I_RST_N, // reset
  input wire logic O_TXD, // line out
  input wire logic I_CTS_N, // clear in
  input wire logic O_RTS_N, // request out
  input wire hwl_wake_cfg_s I_WAKE_CFG, // wake config
  input wire logic I_DEVICE_WAKE_REQUEST, // wake in
  input wire logic O_HOST_WAKE, // wake out
  input wire logic O_STAY_AWAKE, // awake out
  input wire logic O_TX_READY, // tx room
  input wire logic [7:0] O_RX_DATA, // rx byte
  input wire logic O_RX_VALID, // rx valid
  input wire logic I_RX_READY, // rx taken
  input wire logic O_RX_FRAME_ERR // bad stop
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);
  // a frame begun just before clear rose may run 10 bits at the slowest rate
  localparam logic [11:0] CTS_QUIET = 12'hE10;
  logic [11:0] cts_hi_ff;
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N || !I_CTS_N) cts_hi_ff <= 12'h000;
    else if (cts_hi_ff != 12'hFFF) cts_hi_ff <= cts_hi_ff + 12'h001;
  end
  sequence s_rx_wait; O_RX_VALID && !I_RX_READY; endsequence
  sequence s_released; $rose(I_RST_N); endsequence
  property p_rx_hold; s_rx_wait |=> O_RX_VALID && $stable(O_RX_DATA); endproperty
  property p_wake_off; !I_WAKE_CFG.wake_en |=> !O_HOST_WAKE && O_STAY_AWAKE; endproperty
  property p_stay_force;
    I_WAKE_CFG.wake_en && I_WAKE_CFG.device_wake_request_forces_awake
      |=> O_STAY_AWAKE == $past(I_DEVICE_WAKE_REQUEST);
  endproperty
  property p_stay_sleep;
    I_WAKE_CFG.wake_en && !I_WAKE_CFG.device_wake_request_forces_awake |=> !O_STAY_AWAKE;
  endproperty
  property p_host_wake; I_WAKE_CFG.wake_en && I_WAKE_CFG.host_wake_req |=> O_HOST_WAKE; endproperty
  property p_err_pulse; O_RX_FRAME_ERR |=> !O_RX_FRAME_ERR; endproperty
  property p_ready_up; s_released |-> ##[1:2] (O_TX_READY && !O_RTS_N); endproperty
  property p_cts_stop; I_CTS_N && cts_hi_ff >= CTS_QUIET |=> O_TXD; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx byte changed while waiting");
  a_wake_off: assert property (p_wake_off) else $error("wake lines active while disabled");
  a_stay_force: assert property (p_stay_force) else $error("awake not following request");
  a_stay_sleep: assert property (p_stay_sleep) else $error("awake held in permit mode");
  a_host_wake: assert property (p_host_wake) else $error("host wake not raised");
  a_err_pulse: assert property (p_err_pulse) else $error("frame error longer than a cycle");
  a_ready_up: assert property (p_ready_up) else $error("ready or request late after reset");
  a_cts_stop: assert property (p_cts_stop) else $error("frame started while clear high");
endmodule
bind hwl_uart_link hwl_uart_link_chk u_hwl_uart_link_chk (.I_SYS_CLK(I_SYS_CLK),
  .I_RST_N(I_RST_N), .O_TXD(O_TXD), .I_CTS_N(I_CTS_N), .O_RTS_N(O_RTS_N),
  .I_WAKE_CFG(I_WAKE_CFG), .I_DEVICE_WAKE_REQUEST(I_DEVICE_WAKE_REQUEST),
  .O_HOST_WAKE(O_HOST_WAKE), .O_STAY_AWAKE(O_STAY_AWAKE), .O_TX_READY(O_TX_READY),
  .O_RX_DATA(O_RX_DATA), .O_RX_VALID(O_RX_VALID), .I_RX_READY(I_RX_READY),
  .O_RX_FRAME_ERR(O_RX_FRAME_ERR));

// file: sim/hwl_host_model.sv
/*
  Behavioural host serial port facing the link.
  Assumes the bench sets clocks per bit to match the device rate.
*/
`timescale 1ns/10ps
module hwl_host_model (
  input wire logic i_clk, // core clock
  input wire logic [15:0] i_bit_clks, // clocks per bit
  input wire logic i_txd, // line from device
  input wire logic i_rts_n, // device may take data
  output logic o_rxd, // line to device, rests high
  output logic o_cts_n // clear to send to device
);
  logic [7:0] got_byte;
  logic got_stop;
  int got_cnt;
  initial begin
    o_rxd = 1'b1;
    o_cts_n = 1'b0;
    got_cnt = 0;
  end
  task send_byte(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    while (i_rts_n !== 1'b0) begin
      @(posedge i_clk);
      #1;
    end
    for (int i = 0; i < 10; i++) begin
      o_rxd = f[i];
      repeat (i_bit_clks) @(posedge i_clk);
      #1;
    end
    o_rxd = 1'b1;
  endtask
  // mid-bit sampling, so a wrong device rate garbles the byte
  always begin
    @(negedge i_txd);
    repeat (i_bit_clks / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (i_bit_clks) @(posedge i_clk);
      got_byte[i] = i_txd;
    end
    repeat (i_bit_clks) @(posedge i_clk);
    got_stop = i_txd;
    got_cnt++;
  end
endmodule

// file: sim/hwl_uart_link_tb_top.sv
/*
  Self-checking bench for the serial link with a host model on the line.
  Assumes a 40 MHz clock; preset rates plus one custom step on the last rate pass.
*/
`timescale 1ns/10ps
module hwl_uart_link_tb_top import hwl_pkg::*;;
  logic clk, rst_n, rxd, txd, cts_n, rts_n, dwake, hwake, awake;
  logic tx_valid, tx_ready, rx_valid, rx_ready, ferr;
  logic [7:0] tx_data, rx_data;
  logic [15:0] bitc;
  hwl_rate_cfg_s rate;
  hwl_wake_cfg_s wake;
  int err_total, check_count, n, ferr_cnt;
  hwl_uart_link u_hwl_uart_link (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_RXD(rxd), .O_TXD(txd),
    .I_CTS_N(cts_n), .O_RTS_N(rts_n), .I_RATE_CFG(rate), .I_WAKE_CFG(wake),
    .I_DEVICE_WAKE_REQUEST(dwake), .O_HOST_WAKE(hwake), .O_STAY_AWAKE(awake),
    .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid), .O_TX_READY(tx_ready), .O_RX_DATA(rx_data),
    .O_RX_VALID(rx_valid), .I_RX_READY(rx_ready), .O_RX_FRAME_ERR(ferr));
  hwl_host_model u_hwl_host_model (.i_clk(clk), .i_bit_clks(bitc), .i_txd(txd),
    .i_rts_n(rts_n), .o_rxd(rxd), .o_cts_n(cts_n));
  task cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // leaves valid high so back-to-back pushes never toggle it in one step
  task push(input logic [7:0] b);
    tx_data = b;
    tx_valid = 1'b1;
    n = 0;
    while (tx_ready !== 1'b1 && n < 5000) begin tick(1); n++; end
    cmp("push_wait", 8'h01, 8'(n < 5000));
    tick(1);
  endtask
  task pop(input logic [7:0] e);
    n = 0;
    while (rx_valid !== 1'b1 && n < 5000) begin tick(1); n++; end
    cmp("pop_wait", 8'h01, 8'(n < 5000));
    cmp("rx_data", e, rx_data);
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask
  task wait_got(input int c);
    n = 0;
    while (u_hwl_host_model.got_cnt < c && n < 5000) begin tick(1); n++; end
    cmp("got_wait", 8'h01, 8'(n < 5000));
  endtask
  task t_reset;
    tick(3);
    cmp("txd", 8'h01, {7'h0, txd});
    cmp("tx_ready", 8'h00, {7'h0, tx_ready});
    cmp("rts_n", 8'h01, {7'h0, rts_n});
    cmp("wake", 8'h01, {6'h0, hwake, awake});
    tick(1);
    rst_n = 1'b1;
    tick(2);
    cmp("tx_ready", 8'h01, {7'h0, tx_ready});
    cmp("rts_n", 8'h00, {7'h0, rts_n});
  endtask
  task t_wake;
    dwake = 1'b1;
    wake = '{1'b0, 1'b0, 1'b1};
    tick(2);
    cmp("wake", 8'h01, {6'h0, hwake, awake});
    wake = '{1'b1, 1'b1, 1'b0};
    tick(2);
    cmp("wake", 8'h01, {6'h0, hwake, awake});
    dwake = 1'b0;
    tick(2);
    cmp("wake", 8'h00, {6'h0, hwake, awake});
    wake = '{1'b1, 1'b0, 1'b1};
    dwake = 1'b1;
    tick(2);
    cmp("wake", 8'h02, {6'h0, hwake, awake});
  endtask
  task t_tx_default;
    push(8'hA5);
    tx_valid = 1'b0;
    wait_got(1);
    cmp("got", 8'hA5, u_hwl_host_model.got_byte);
    cmp("stop", 8'h01, {7'h0, u_hwl_host_model.got_stop});
  endtask
  task t_rates;
    int c;
    logic [15:0] bc [4];
    bc = '{16'h002B, 16'h001B, 16'h000D, 16'h0014};
    for (int i = 0; i < 4; i++) begin
      // last pass: custom step of 0.4 tick per clock, 2 Mbps, 20 clocks a bit
      rate = '{i == 3, 2'(i + 1), 16'h6666};
      bitc = bc[i];
      c = u_hwl_host_model.got_cnt;
      push(8'h81 ^ 8'(i));
      push(8'h7E);
      tx_valid = 1'b0;
      wait_got(c + 1);
      cmp("got", 8'h81 ^ 8'(i), u_hwl_host_model.got_byte);
      wait_got(c + 2);
      cmp("got", 8'h7E, u_hwl_host_model.got_byte);
      u_hwl_host_model.send_byte(8'h5A ^ 8'(i), 1'b1);
      pop(8'h5A ^ 8'(i));
    end
  endtask
  task t_cts;
    int c;
    c = u_hwl_host_model.got_cnt;
    wake = '{1'b1, 1'b0, 1'b0};
    u_hwl_host_model.o_cts_n = 1'b1;
    push(8'h3C);
    tx_valid = 1'b0;
    // outlasts the checker's quiet window so its clear-to-send check engages
    tick(3700);
    cmp("txd", 8'h01, {7'h0, txd});
    cmp("cnt", 8'(c), 8'(u_hwl_host_model.got_cnt));
    cmp("hwake", 8'h01, {7'h0, hwake});
    u_hwl_host_model.o_cts_n = 1'b0;
    wait_got(c + 1);
    cmp("got", 8'h3C, u_hwl_host_model.got_byte);
    cmp("hwake", 8'h00, {7'h0, hwake});
  endtask
  task t_ferr;
    int c;
    c = ferr_cnt;
    u_hwl_host_model.send_byte(8'hC3, 1'b0);
    tick(16);
    cmp("ferr", 8'(c + 1), 8'(ferr_cnt));
    cmp("rx_valid", 8'h00, {7'h0, rx_valid});
  endtask
  task print_verdict;
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(negedge clk) if (ferr === 1'b1) ferr_cnt++;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    print_verdict;
  end
  initial begin
    {rst_n, tx_valid, rx_ready, dwake, tx_data} = '0;
    {wake, rate, err_total, check_count, ferr_cnt} = '0;
    bitc = 16'h015B;
    t_reset;
    t_wake;
    t_tx_default;
    t_rates;
    t_cts;
    t_ferr;
    print_verdict;
  end
endmodule
